// File: rtl/cps_pkg.sv
// Package for the clock prescaler and sleep controller.
// Assumes a single 20 MHz clock and a synchronous active-low reset.
package cps_pkg;

  // ***********************************************************************
  // Register map
  // ***********************************************************************
  // Byte address of the clock divide control register.
  localparam logic [3:0] CPS_ADDR_CLKDIV = 4'h0;
  // Byte address of the power and sleep control register.
  localparam logic [3:0] CPS_ADDR_PWRSLP = 4'h1;
  // Byte address of the read-only sleep status register.
  localparam logic [3:0] CPS_ADDR_STATUS = 4'h2;

  // ***********************************************************************
  // Field positions
  // ***********************************************************************
  // Divide change unlock bit in the clock divide register.
  localparam int CPS_DIV_UNLOCK_BIT = 7;
  // Brown-out sleep disable bit in the power register.
  localparam int CPS_BOD_DIS_BIT = 7;
  // General purpose bit kept for the pull-up control.
  localparam int CPS_PULLUP_BIT = 6;
  // Sleep arm bit in the power register.
  localparam int CPS_SLEEP_ARM_BIT = 5;
  // Upper bit of the sleep kind field.
  localparam int CPS_KIND_HI_BIT = 4;
  // Lower bit of the sleep kind field.
  localparam int CPS_KIND_LO_BIT = 3;
  // Brown-out sleep unlock bit in the power register.
  localparam int CPS_BOD_UNLOCK_BIT = 2;

  // ***********************************************************************
  // Reset values and select limit
  // ***********************************************************************
  // Division select after reset with the fuse unprogrammed.
  localparam logic [3:0] CPS_DIV_RESET_PLAIN = 4'h0;
  // Division select after reset with the fuse programmed.
  localparam logic [3:0] CPS_DIV_RESET_DIV8 = 4'h3;
  // Power register value after reset.
  localparam logic [7:0] CPS_PWR_RESET = 8'h00;
  // Highest legal division select code.
  localparam logic [3:0] CPS_DIV_MAX = 4'h8;

  // ***********************************************************************
  // Timing
  // ***********************************************************************
  // Length of an unlock window in clock cycles.
  localparam logic [2:0] CPS_UNLOCK_CYCLES = 3'h4;
  // Delay before the brown-out disable becomes active.
  localparam logic [2:0] CPS_BOD_ACT_CYCLES = 3'h3;
  // Time the brown-out disable stays active.
  localparam logic [2:0] CPS_BOD_LIFE_CYCLES = 3'h3;
  // Extra halt cycles after a wake-up.
  localparam logic [2:0] CPS_WAKE_HALT_CYCLES = 3'h4;
  // Start-up time of the oscillator in cycles.
  localparam logic [7:0] CPS_STARTUP_CYCLES = 8'h06;

  // ***********************************************************************
  // Types
  // ***********************************************************************
  // Sleep kind encoding.
  typedef enum logic [1:0] {
    CPS_KIND_IDLE,
    CPS_KIND_ADC_NR,
    CPS_KIND_PWR_DOWN,
    CPS_KIND_STANDBY
  } cps_kind_e;

  // Sleep sequencer states.
  typedef enum logic [1:0] {
    CPS_ST_RUN,
    CPS_ST_SLEEP,
    CPS_ST_START,
    CPS_ST_HALT
  } cps_state_e;

endpackage : cps_pkg

// File: rtl/cps_div_if.sv
// Interface carrying the division request into the divider.
// Assumes both ends run on the same master clock.
`timescale 1ns/100ps
`default_nettype none
interface cps_div_if;
  // Division select currently stored in the register.
  logic [3:0] sel;
  // One-cycle tick marking an active edge of the divided clock.
  logic tick;
  // Divided clock level.
  logic level;
  // Controller end drives the select.
  modport ctrl (output sel, input tick, input level);
  // Divider end produces the divided clock.
  modport div (input sel, output tick, output level);
endinterface : cps_div_if
`default_nettype wire

// File: rtl/cps_divider.sv
// Glitch-free power-of-two divider of the master clock.
// Assumes the select comes from a register on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cps_divider
  import cps_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  cps_div_if.div dv
);

  // Count on the undivided clock, cleared at each half-period end.
  logic [7:0] cnt_r;
  // Select in force for the current period.
  logic [3:0] sel_r;
  // Output clock level.
  logic level_r;
  // Half-period reached for the select in force.
  logic half_done;
  // Tick pulse output.
  logic tick_r;

  // Half-period end: the low bits are all ones for the select in force.
  always_comb begin
    half_done = 1'b1;
    if (sel_r != 4'h0) begin
      half_done = ((cnt_r | ~((8'h01 << (sel_r - 4'h1)) - 8'h01)) == 8'hff);
    end
  end

  // ***********************************************************************
  // Counter and output
  // ***********************************************************************
  // The new select is taken only at a period boundary, so no period is
  // cut short and two active edges elapse before the new rate holds.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      sel_r <= 4'h0;
      level_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (sel_r == 4'h0) begin
        // Divide by one: a tick on every edge.
        tick_r <= 1'b1;
        level_r <= ~level_r;
        cnt_r <= 8'h00;
        sel_r <= (dv.sel > CPS_DIV_MAX) ? CPS_DIV_MAX : dv.sel;
      end else if (half_done) begin
        cnt_r <= 8'h00;
        level_r <= ~level_r;
        if (!level_r) begin
          tick_r <= 1'b1;
        end else begin
          // Falling edge ends the period; adopt a new select here.
          sel_r <= (dv.sel > CPS_DIV_MAX) ? CPS_DIV_MAX : dv.sel;
        end
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  assign dv.tick = tick_r;
  assign dv.level = level_r;

endmodule : cps_divider
`default_nettype wire

// File: rtl/cps_ctrl.sv
// Clock prescaler and sleep controller, top module.
// Assumes a 20 MHz clock, synchronous active-low reset, a plain register
// port and a fuse level that is stable around reset.
//
// Function
// - unlock bit updates only with others zero
// - unlock clears after four cycles or select write
// - rewriting unlock neither restarts nor clears
// - prescale bits six to four read zero
// - divide by two to select, codes 0-8
// - fuse chooses reset select zero or three
// - any select accepted regardless of fuse
// - division change is glitch free
// - ripple counter on master clock, not readable
// - new rate after two active edges
// - sleep needs arm bit and sleep instruction
// - kind codes idle, adc, power-down, standby
// - wake stalls four cycles plus start-up
// - state kept; reset in sleep restarts
// - brown-out disable needs timed unlock write
// - brown-out disable active three, lasts three (code keeps it active four cycles)
// - no brown-out disable variant reads zero
// - idle stops cpu and flash clocks only
// - idle entry starts adc conversion if enabled
// - adc mode stops io, cpu, flash clocks
// - power-down stops oscillator and all clocks
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module cps_ctrl
  import cps_pkg::*;
#(
  // One when the brown-out sleep disable feature exists.
  parameter bit HAS_BOD_DISABLE = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic divide_by_eight_fuse,
  input wire logic sleep_instr,
  input wire logic wake_irq,
  input wire logic adc_enabled,
  output logic cpu_clk_en,
  output logic flash_clk_en,
  output logic io_clk_en,
  output logic adc_clk_en,
  output logic osc_en,
  output logic bod_off,
  output logic adc_start,
  output logic cpu_stall,
  output logic sys_clk,
  output logic sys_tick
);

  // ***********************************************************************
  // Declarations
  // ***********************************************************************
  // Division select field.
  logic [3:0] division_select_r;
  // Divide change unlock bit.
  logic divide_change_unlock_r;
  // Cycles since the unlock bit was set.
  logic [2:0] unlock_cnt_r;
  // Power register bits other than the brown-out pair.
  logic pullup_r;
  logic sleep_arm_r;
  logic [1:0] sleep_kind_r;
  logic [1:0] irq_sense_r;
  // Brown-out unlock bit and its window counter.
  logic brownout_sleep_unlock_r;
  logic [2:0] bod_unlock_cnt_r;
  // Brown-out disable bit, its age, and active flag.
  logic brownout_sleep_disable_r;
  logic [2:0] bod_age_r;
  logic bod_active;
  // Sleep sequencer.
  cps_state_e state_r;
  cps_kind_e kind_taken_r;
  logic [7:0] wait_cnt_r;
  // Registered outputs.
  logic [7:0] rdata_r;
  logic cpu_clk_en_r, flash_clk_en_r, io_clk_en_r, adc_clk_en_r, osc_en_r;
  logic bod_off_r, adc_start_r, cpu_stall_r, sys_clk_r, sys_tick_r;
  // Reset has just been released; used to catch the fuse.
  logic fuse_load_r;
  // Write strobes per register.
  logic wr_div, wr_pwr;
  // Sleep entry condition.
  logic enter_sleep;
  // Connection to the divider.
  cps_div_if dv ();

  // Decodes a bus address against a register address.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  assign wr_div = wr && hit(addr, CPS_ADDR_CLKDIV);
  assign wr_pwr = wr && hit(addr, CPS_ADDR_PWRSLP);

  // ***********************************************************************
  // Clock divide control
  // ***********************************************************************
  // Fuse is caught on the first clock after reset, never by the reset.
  always_ff @(posedge clock) begin
    fuse_load_r <= !resetn;
  end

  // Unlock bit and its window.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      divide_change_unlock_r <= 1'b0;
      unlock_cnt_r <= 3'h0;
    end else if (!divide_change_unlock_r) begin
      if (wr_div && wdata[CPS_DIV_UNLOCK_BIT] && (wdata[6:0] == 7'h00)) begin
        divide_change_unlock_r <= 1'b1;
        unlock_cnt_r <= 3'h1;
      end
    end else if ((wr_div && !wdata[CPS_DIV_UNLOCK_BIT]) ||
                 (unlock_cnt_r == CPS_UNLOCK_CYCLES)) begin
      // select write or timeout clears, rewrite does not
      divide_change_unlock_r <= 1'b0;
    end else begin
      unlock_cnt_r <= unlock_cnt_r + 3'h1;
    end
  end

  // Division select storage.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      division_select_r <= CPS_DIV_RESET_PLAIN;
    end else if (fuse_load_r) begin
      division_select_r <= divide_by_eight_fuse ? CPS_DIV_RESET_DIV8 :
                           CPS_DIV_RESET_PLAIN;
    end else if (wr_div && divide_change_unlock_r &&
                 !wdata[CPS_DIV_UNLOCK_BIT]) begin
      division_select_r <= wdata[3:0];
    end
  end

  assign dv.sel = division_select_r;
  cps_divider u_div (
    .clock(clock),
    .resetn(resetn),
    .dv(dv)
  );

  // ***********************************************************************
  // Power and sleep control
  // ***********************************************************************
  // Plain control bits; they keep their value through sleep.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pullup_r <= CPS_PWR_RESET[CPS_PULLUP_BIT];
      sleep_arm_r <= CPS_PWR_RESET[CPS_SLEEP_ARM_BIT];
      sleep_kind_r <= CPS_PWR_RESET[CPS_KIND_HI_BIT:CPS_KIND_LO_BIT];
      irq_sense_r <= CPS_PWR_RESET[1:0];
    end else if (wr_pwr) begin
      pullup_r <= wdata[CPS_PULLUP_BIT];
      sleep_arm_r <= wdata[CPS_SLEEP_ARM_BIT];
      sleep_kind_r <= wdata[CPS_KIND_HI_BIT:CPS_KIND_LO_BIT];
      irq_sense_r <= wdata[1:0];
    end
  end

  // Brown-out unlock: set by writing both bits, lasts four cycles.
  always_ff @(posedge clock) begin
    if (!resetn || !HAS_BOD_DISABLE) begin
      brownout_sleep_unlock_r <= 1'b0;
      bod_unlock_cnt_r <= 3'h0;
    end else if (wr_pwr && wdata[CPS_BOD_DIS_BIT] &&
                 wdata[CPS_BOD_UNLOCK_BIT]) begin
      brownout_sleep_unlock_r <= 1'b1;
      bod_unlock_cnt_r <= 3'h1;
    end else if (brownout_sleep_unlock_r) begin
      if ((wr_pwr && !wdata[CPS_BOD_UNLOCK_BIT]) ||
          bod_unlock_cnt_r == CPS_UNLOCK_CYCLES) begin
        brownout_sleep_unlock_r <= 1'b0;
      end else begin
        bod_unlock_cnt_r <= bod_unlock_cnt_r + 3'h1;
      end
    end
  end

  // Brown-out disable bit with its activation delay and self clear.
  always_ff @(posedge clock) begin
    if (!resetn || !HAS_BOD_DISABLE) begin
      // absent feature keeps both bits zero
      brownout_sleep_disable_r <= 1'b0;
      bod_age_r <= 3'h0;
    end else if (wr_pwr && brownout_sleep_unlock_r &&
                 wdata[CPS_BOD_DIS_BIT] && !wdata[CPS_BOD_UNLOCK_BIT]) begin
      brownout_sleep_disable_r <= 1'b1;
      bod_age_r <= 3'h0;
    end else if (brownout_sleep_disable_r) begin
      // active after three, cleared after four more
      if (bod_age_r == CPS_BOD_ACT_CYCLES + CPS_BOD_LIFE_CYCLES - 3'h1) begin
        brownout_sleep_disable_r <= 1'b0;
      end
      bod_age_r <= bod_age_r + 3'h1;
    end
  end

  assign bod_active = brownout_sleep_disable_r &&
                      (bod_age_r >= CPS_BOD_ACT_CYCLES - 3'h1);

  // arm bit and instruction both needed
  assign enter_sleep = sleep_arm_r && sleep_instr;

  // ***********************************************************************
  // Sleep sequencer
  // ***********************************************************************
  // A reset in any state returns to run through the reset branch.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= CPS_ST_RUN;
      kind_taken_r <= CPS_KIND_IDLE;
      wait_cnt_r <= 8'h00;
      bod_off_r <= 1'b0;
    end else begin
      unique case (state_r)
        CPS_ST_RUN: begin
          if (enter_sleep) begin
            state_r <= CPS_ST_SLEEP;
            kind_taken_r <= cps_kind_e'(sleep_kind_r);
            bod_off_r <= bod_active;
          end
        end
        CPS_ST_SLEEP: begin
          if (wake_irq) begin
            state_r <= CPS_ST_START;
            wait_cnt_r <= CPS_STARTUP_CYCLES;
            bod_off_r <= 1'b0;
          end
        end
        CPS_ST_START: begin
          if (wait_cnt_r == 8'h01) begin
            state_r <= CPS_ST_HALT;
            wait_cnt_r <= {5'h00, CPS_WAKE_HALT_CYCLES};
          end else begin
            wait_cnt_r <= wait_cnt_r - 8'h01;
          end
        end
        CPS_ST_HALT: begin
          if (wait_cnt_r == 8'h01) begin
            state_r <= CPS_ST_RUN;
          end else begin
            wait_cnt_r <= wait_cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  // Clock gating per sleep kind.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpu_clk_en_r <= 1'b1;
      flash_clk_en_r <= 1'b1;
      io_clk_en_r <= 1'b1;
      adc_clk_en_r <= 1'b1;
      osc_en_r <= 1'b1;
    end else if (state_r == CPS_ST_SLEEP && !wake_irq) begin
      cpu_clk_en_r <= 1'b0;
      flash_clk_en_r <= 1'b0;
      io_clk_en_r <= 1'b0;
      adc_clk_en_r <= 1'b0;
      osc_en_r <= 1'b1;
      unique case (kind_taken_r)
        CPS_KIND_IDLE: begin
          io_clk_en_r <= 1'b1;
          adc_clk_en_r <= 1'b1;
        end
        CPS_KIND_ADC_NR: begin
          adc_clk_en_r <= 1'b1;
        end
        CPS_KIND_PWR_DOWN: begin
          osc_en_r <= 1'b0;
        end
        CPS_KIND_STANDBY: begin
        end
      endcase
    end else begin
      cpu_clk_en_r <= (state_r == CPS_ST_RUN);
      flash_clk_en_r <= (state_r == CPS_ST_RUN);
      io_clk_en_r <= 1'b1;
      adc_clk_en_r <= 1'b1;
      osc_en_r <= 1'b1;
    end
  end

  // Stall, ADC start and divided clock outputs.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cpu_stall_r <= 1'b0;
      adc_start_r <= 1'b0;
      sys_clk_r <= 1'b0;
      sys_tick_r <= 1'b0;
    end else begin
      cpu_stall_r <= (state_r != CPS_ST_RUN);
      // conversion on idle or adc entry
      adc_start_r <= enter_sleep && (state_r == CPS_ST_RUN) && adc_enabled &&
                     (sleep_kind_r[1] == 1'b0);
      sys_clk_r <= dv.level;
      sys_tick_r <= dv.tick;
    end
  end

  // ***********************************************************************
  // Read port
  // ***********************************************************************
  // Read data stand in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= 8'h00;
      if (rd && hit(addr, CPS_ADDR_CLKDIV)) begin
        rdata_r <= {divide_change_unlock_r, 3'h0, division_select_r};
      end else if (rd && hit(addr, CPS_ADDR_PWRSLP)) begin
        rdata_r <= {brownout_sleep_disable_r, pullup_r, sleep_arm_r,
                    sleep_kind_r, brownout_sleep_unlock_r, irq_sense_r};
      end else if (rd && hit(addr, CPS_ADDR_STATUS)) begin
        rdata_r <= {5'h00, bod_active, state_r};
      end
    end
  end

  assign rdata = rdata_r;
  assign cpu_clk_en = cpu_clk_en_r;
  assign flash_clk_en = flash_clk_en_r;
  assign io_clk_en = io_clk_en_r;
  assign adc_clk_en = adc_clk_en_r;
  assign osc_en = osc_en_r;
  assign bod_off = bod_off_r;
  assign adc_start = adc_start_r;
  assign cpu_stall = cpu_stall_r;
  assign sys_clk = sys_clk_r;
  assign sys_tick = sys_tick_r;

endmodule : cps_ctrl
`default_nettype wire

// File: verif/cps_ctrl_props.sv
// Concurrent checks on the ports of the prescaler and sleep controller.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module cps_ctrl_props
  import cps_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic divide_by_eight_fuse,
  input wire logic sleep_instr,
  input wire logic wake_irq,
  input wire logic adc_enabled,
  input wire logic cpu_clk_en,
  input wire logic flash_clk_en,
  input wire logic io_clk_en,
  input wire logic adc_clk_en,
  input wire logic osc_en,
  input wire logic bod_off,
  input wire logic adc_start,
  input wire logic cpu_stall,
  input wire logic sys_clk,
  input wire logic sys_tick
);
  // ***********************************************************************
  // Assertions
  // ***********************************************************************
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  AST_DIV_RESERVED_ZERO: assert property (
    $past(rd) && $past(addr) == CPS_ADDR_CLKDIV |-> rdata[6:4] == 3'h0)
    else $error("Reserved divide bits read nonzero.");
  AST_SLEEP_CAUSE: assert property (
    $rose(cpu_stall) |-> $past(sleep_instr) || $past(sleep_instr, 2))
    else $error("Stall began without a sleep instruction.");
  AST_RUN_CLOCKS: assert property (
    !cpu_stall |-> cpu_clk_en && flash_clk_en && io_clk_en && osc_en)
    else $error("A clock stopped while running.");
  AST_FLASH_WITH_CPU: assert property (
    !flash_clk_en |-> !cpu_clk_en)
    else $error("CPU clock ran while flash clock stopped.");
  AST_IO_STOP: assert property (
    !io_clk_en |-> !cpu_clk_en && !flash_clk_en)
    else $error("CPU clock ran while the I/O clock stopped.");
  AST_OSC_STOP: assert property (
    !osc_en |-> !adc_clk_en && !io_clk_en && !cpu_clk_en)
    else $error("A clock ran with the oscillator off.");
  AST_ADC_PULSE: assert property (
    adc_start |-> $past(adc_enabled) ##1 !adc_start)
    else $error("Conversion start was not a single qualified pulse.");
  AST_BOD_IN_SLEEP: assert property (
    bod_off |=> cpu_stall)
    else $error("Brown-out detector off while running.");
  AST_TICK_ON_RISE: assert property (
    sys_tick && !$past(sys_tick) |-> sys_clk && !$past(sys_clk))
    else $error("Divided tick without a rising divided clock.");
  AST_WAKE_BOUND: assert property (
    cpu_stall && wake_irq |-> ##[1:24] !cpu_stall)
    else $error("No wake-up within the allowed time.");

  // Main scenarios reached.
  COV_ADC_START: cover property (adc_start);
  COV_BOD_OFF: cover property ($rose(bod_off));
  COV_SLEEP: cover property ($rose(cpu_stall) ##[1:8] !osc_en);
endmodule // cps_ctrl_props

bind cps_ctrl cps_ctrl_props i_cps_ctrl_props (
  .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .divide_by_eight_fuse(divide_by_eight_fuse),
  .sleep_instr(sleep_instr), .wake_irq(wake_irq),
  .adc_enabled(adc_enabled), .cpu_clk_en(cpu_clk_en),
  .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
  .adc_clk_en(adc_clk_en), .osc_en(osc_en), .bod_off(bod_off),
  .adc_start(adc_start), .cpu_stall(cpu_stall), .sys_clk(sys_clk),
  .sys_tick(sys_tick));
`default_nettype wire

// File: verif/cps_ctrl_bench.sv
// Self-checking bench for the prescaler and sleep controller.
// Assumes the register map and timing held in cps_pkg.
`timescale 1ns/100ps
`default_nettype none
module cps_ctrl_bench
  import cps_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic fuse = 1'b0;
  logic slp = 1'b0;
  logic irq = 1'b0;
  logic adc_en = 1'b1;
  logic seen_adc = 1'b0;
  logic cpu_en, fl_en, io_en, adc_ck, osc, bod_off, adc_start, stall;
  logic sclk, tick;
  int failures = 0;
  int comparisons = 0;

  // Clock of 50 ns period; remembers a conversion start since a write.
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (adc_start) seen_adc <= 1'b1;
    else if (wr) seen_adc <= 1'b0;
  end

  cps_ctrl #(.HAS_BOD_DISABLE(1'b1)) i_cps_ctrl (
    .clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .divide_by_eight_fuse(fuse), .sleep_instr(slp),
    .wake_irq(irq), .adc_enabled(adc_en), .cpu_clk_en(cpu_en),
    .flash_clk_en(fl_en), .io_clk_en(io_en), .adc_clk_en(adc_ck),
    .osc_en(osc), .bod_off(bod_off), .adc_start(adc_start),
    .cpu_stall(stall), .sys_clk(sclk), .sys_tick(tick));

  // ***********************************************************************
  // Helpers
  // ***********************************************************************
  task automatic final_report();
    $display("Comparisons %0d, failures %0d.", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(string what, logic [3:0] a, logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  // Counts cycles up to the next divided tick, with a bound.
  task automatic next_tick(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 600);
    if (n >= 600) begin
      failures++;
      final_report();
    end
  endtask

  task automatic set_div(logic [7:0] code);
    wr_reg(4'h0, 8'h80);
    wr_reg(4'h0, code);
  endtask

  task automatic pulse_sleep();
    @(posedge clock);
    slp <= 1'b1;
    @(posedge clock);
    slp <= 1'b0;
    cycles(3);
    #1;
  endtask

  // Raises the wake request and measures the stall that follows.
  task automatic wake(output int n);
    @(posedge clock);
    irq <= 1'b1;
    n = 0;
    while (stall === 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    irq <= 1'b0;
    if (n >= 40) begin
      failures++;
      final_report();
    end
  endtask

  // ***********************************************************************
  // Scenarios
  // ***********************************************************************
  task automatic unlock_rules();
    set_div(8'h02);
    wr_reg(4'h0, 8'h81);
    rd_chk("unlock_with_bits", 4'h0, 8'h02);
    wr_reg(4'h0, 8'h05);
    rd_chk("locked_write", 4'h0, 8'h02);
    wr_reg(4'h0, 8'h80);
    rd_chk("unlock_bit", 4'h0, 8'h82);
    cycles(4);
    wr_reg(4'h0, 8'h05);
    rd_chk("expired_unlock", 4'h0, 8'h02);
    wr_reg(4'h0, 8'h80);
    wr_reg(4'h0, 8'h80);
    cycles(2);
    wr_reg(4'h0, 8'h05);
    rd_chk("rewrite_no_extend", 4'h0, 8'h02);
    set_div(8'h71);
    rd_chk("reserved_bits", 4'h0, 8'h01);
    set_div(8'h0c);
    rd_chk("reserved_code", 4'h0, 8'h0c);
    rd_chk("unmapped", 4'h9, 8'h00);
  endtask

  task automatic div_sweep();
    int n;
    for (int c = 0; c <= 8; c++) begin
      set_div(8'(c));
      rd_chk("division_select", 4'h0, 8'(c));
      repeat (3) next_tick(n);
      next_tick(n);
      chk("divided_period", 16'(1 << c), 16'(n));
    end
  endtask

  task automatic sleep_kind(logic [1:0] k, logic [5:0] exp, logic ae);
    int n;
    wr_reg(4'h1, {3'b001, k, 3'b000});
    pulse_sleep();
    chk("clocks", 16'(exp), 16'({cpu_en, fl_en, io_en, adc_ck, osc, bod_off}));
    chk("adc_start", 16'(ae), 16'(seen_adc));
    wake(n);
    chk("wake_delay", 16'h0001, 16'(n >= 10 && n <= 14));
    rd_chk("sleep_ctrl_kept", 4'h1, {3'b001, k, 3'b000});
  endtask

  task automatic bod_and_arm();
    int n;
    wr_reg(4'h1, 8'h10);
    pulse_sleep();
    chk("unarmed_stall", 16'h0000, 16'(stall));
    wr_reg(4'h1, 8'ha4);
    wr_reg(4'h1, 8'ha0);
    cycles(2);
    pulse_sleep();
    chk("bod_off", 16'h0001, 16'(bod_off));
    wake(n);
  endtask

  task automatic fuse_reset();
    int n;
    wr_reg(4'h1, 8'h30);
    pulse_sleep();
    @(posedge clock);
    resetn <= 1'b0;
    fuse <= 1'b1;
    cycles(16);
    resetn <= 1'b1;
    cycles(2);
    #1;
    chk("reset_in_sleep", 16'h0000, 16'(stall));
    rd_chk("fuse_reset", 4'h0, 8'h03);
    repeat (3) next_tick(n);
    next_tick(n);
    chk("fuse_period", 16'h0008, 16'(n));
    set_div(8'h00);
    rd_chk("any_select", 4'h0, 8'h00);
  endtask

  initial begin
    cycles(16);
    resetn <= 1'b1;
    cycles(1);
    rd_chk("power_reset", 4'h1, 8'h00);
    rd_chk("div_reset", 4'h0, 8'h00);
    unlock_rules();
    div_sweep();
    sleep_kind(2'b00, 6'b001110, 1'b1);
    sleep_kind(2'b01, 6'b000110, 1'b1);
    sleep_kind(2'b10, 6'b000000, 1'b0);
    sleep_kind(2'b11, 6'b000010, 1'b0);
    bod_and_arm();
    fuse_reset();
    final_report();
  end
endmodule // cps_ctrl_bench
`default_nettype wire
